// *** verilog/scc_pkg.sv ***
// constants, field layout and config carrier for the serial companding control register
`default_nettype none
package scc_pkg;
  localparam int SCC_DATA_W = 16;
  localparam int SCC_ADDR_W = 3;
  localparam int SCC_NUM_EVENTS = 4;

  // i/o port numbers of the two halves
  localparam logic [2:0] SCC_PORT_LOW = 3'h0;
  localparam logic [2:0] SCC_PORT_HIGH = 3'h1;

  // low half field positions
  localparam int SCC_FLAG_LSB = 0;
  localparam int SCC_MASK_LSB = 4;
  localparam int SCC_PORT1_SEL_BIT = 8;
  localparam int SCC_EXT_FRAME_BIT = 9;
  localparam int SCC_OUT_FLAG_BIT = 10;
  localparam int SCC_COMP_MODE_BIT = 11;
  localparam int SCC_COMP_EN_LSB = 12;
  localparam int SCC_ALAW_BIT = 14;
  localparam int SCC_CLK_DIR_BIT = 15;

  // high half field positions, relative to bit 16
  localparam int SCC_MOD_LSB = 0;
  localparam int SCC_PRESCALE_LSB = 8;
  localparam int SCC_FR_WIDTH_BIT = 12;
  localparam int SCC_IO_CTL_LSB = 13;
  localparam int SCC_RSVD_BIT = 15;

  // event order inside the flag field
  localparam int SCC_EV_EXT = 0;
  localparam int SCC_EV_RX_FS = 1;
  localparam int SCC_EV_TX_FS = 2;
  localparam int SCC_EV_FRAME = 3;

  // reset values; clock pin starts as an input
  localparam logic [15:0] SCC_LOW_RST = 16'h8000;
  localparam logic [15:0] SCC_HIGH_RST = 16'h0000;
  localparam logic [15:0] SCC_READ_NONE = 16'h0000;

  typedef struct packed {
    logic [3:0] int_mask;
    logic port1_upper;
    logic ext_framing;
    logic general_output_flag;
    logic compand_mode;
    logic [1:0] compand_en;
    logic alaw_sel;
    logic sclk_is_input;
    logic [7:0] frame_modulus;
    logic [3:0] sclk_prescale;
    logic frame_pulse_long;
    logic [1:0] io_control;
  } scc_cfg_s;
endpackage
`default_nettype wire

// *** verilog/scc_event_flags.sv ***
// sticky event flags with write-one clear, set winning over clear
`timescale 1ns/1ns
`default_nettype none
module scc_event_flags #(
  parameter int N = 4
) (
  input wire logic clk_sys, // system clock
  input wire logic sys_rst, // async reset, active high
  input wire logic [N-1:0] ev_in, // event inputs, active high
  input wire logic [N-1:0] clr, // one-cycle clear per flag
  output logic [N-1:0] flags, // sticky flags
  output logic [N-1:0] ev_pulse // rising-edge pulse per event
);
  logic [N-1:0] prev_reg;
  logic [N-1:0] flag_reg;

  for (genvar i = 0; i < N; i++) begin : g_flag
    assign ev_pulse[i] = ev_in[i] & ~prev_reg[i];

    always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
        prev_reg[i] <= 1'b0;
      end else begin
        prev_reg[i] <= ev_in[i];
      end
    end

    // set has priority so an event in the clear cycle survives
    always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
        flag_reg[i] <= 1'b0;
      end else if (ev_pulse[i]) begin
        flag_reg[i] <= 1'b1;
      end else if (clr[i]) begin
        flag_reg[i] <= 1'b0;
      end
    end
  end

  assign flags = flag_reg;
endmodule
`default_nettype wire

// *** verilog/scc_control_regs.sv ***
// 32-bit serial/companding system control register reached over i/o ports 0 and 1
`timescale 1ns/1ns
`default_nettype none
module scc_control_regs
  import scc_pkg::*;
(
  input wire logic clk_sys, // system clock, 125 MHz
  input wire logic sys_rst, // async reset, active high
  input wire logic [SCC_ADDR_W-1:0] port_addr, // i/o port number
  input wire logic port_wr, // port write strobe, one cycle
  input wire logic port_rd, // port read strobe, one cycle
  input wire logic [SCC_DATA_W-1:0] port_wdata, // port write data
  output logic [SCC_DATA_W-1:0] port_rdata, // read data, registered
  output logic port_rvalid, // read data valid pulse
  output logic port1_external, // port 1 not mapped here
  input wire logic external_interrupt_input, // external interrupt, active high
  input wire logic receive_frame_sync, // receive frame sync, active high
  input wire logic transmit_frame_sync, // transmit frame sync, active high
  input wire logic frame_sync_pulse, // frame pulse, active high
  output scc_cfg_s cfg, // decoded control fields
  output logic general_output_flag, // general output flag pin
  output logic sclk_is_input, // bit clock pin direction
  output logic frame_transfer_start, // frame-triggered transfer pulse
  output logic [SCC_NUM_EVENTS-1:0] int_flags, // live interrupt flags
  output logic master_int // masked flags or-ed, registered
);
  logic [15:4] low_reg;
  logic [14:0] high_reg;
  logic [SCC_DATA_W-1:0] rdata_reg;
  logic rvalid_reg;
  logic master_int_reg;
  logic [SCC_NUM_EVENTS-1:0] ev_in;
  logic [SCC_NUM_EVENTS-1:0] ev_pulse;
  logic [SCC_NUM_EVENTS-1:0] flag_clr;
  logic [SCC_NUM_EVENTS-1:0] flags;
  logic wr_low;
  logic wr_high;
  logic rd_low;
  logic rd_high;

  // port decode; port 1 reaches the upper half only when routed
  assign wr_low = port_wr && (port_addr == SCC_PORT_LOW);
  assign wr_high = port_wr && (port_addr == SCC_PORT_HIGH) && cfg.port1_upper;
  assign rd_low = port_rd && (port_addr == SCC_PORT_LOW);
  assign rd_high = port_rd && (port_addr == SCC_PORT_HIGH) && cfg.port1_upper;
  assign port1_external = ~cfg.port1_upper;

  // event inputs in flag order
  always_comb begin
    ev_in = '0;
    ev_in[SCC_EV_EXT] = external_interrupt_input;
    ev_in[SCC_EV_RX_FS] = receive_frame_sync;
    ev_in[SCC_EV_TX_FS] = transmit_frame_sync;
    ev_in[SCC_EV_FRAME] = frame_sync_pulse;
  end

  // write-one-to-clear on the flag field
  assign flag_clr = wr_low ? port_wdata[SCC_FLAG_LSB +: SCC_NUM_EVENTS] : '0;

  scc_event_flags #(
    .N(SCC_NUM_EVENTS)
  ) u_flags (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .ev_in(ev_in),
    .clr(flag_clr),
    .flags(flags),
    .ev_pulse(ev_pulse)
  );

  // low half storage, flag bits live in the flag bank
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      low_reg <= SCC_LOW_RST[15:4];
    end else if (wr_low) begin
      low_reg <= port_wdata[15:4];
    end
  end

  // high half storage; reserved bit never stored
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      high_reg <= SCC_HIGH_RST[14:0];
    end else if (wr_high) begin
      high_reg <= port_wdata[14:0];
    end
  end

  // field decode of the low and high halves
  always_comb begin
    cfg.int_mask = low_reg[SCC_MASK_LSB +: 4];
    cfg.port1_upper = low_reg[SCC_PORT1_SEL_BIT];
    cfg.ext_framing = low_reg[SCC_EXT_FRAME_BIT];
    cfg.general_output_flag = low_reg[SCC_OUT_FLAG_BIT];
    cfg.compand_mode = low_reg[SCC_COMP_MODE_BIT];
    cfg.compand_en = low_reg[SCC_COMP_EN_LSB +: 2];
    cfg.alaw_sel = low_reg[SCC_ALAW_BIT];
    cfg.sclk_is_input = low_reg[SCC_CLK_DIR_BIT];
    cfg.frame_modulus = high_reg[SCC_MOD_LSB +: 8];
    cfg.sclk_prescale = high_reg[SCC_PRESCALE_LSB +: 4];
    cfg.frame_pulse_long = high_reg[SCC_FR_WIDTH_BIT];
    cfg.io_control = high_reg[SCC_IO_CTL_LSB +: 2];
  end

  assign general_output_flag = cfg.general_output_flag;
  assign sclk_is_input = cfg.sclk_is_input;
  assign int_flags = flags;

  // transfers start on a frame pulse only with external framing on
  assign frame_transfer_start = ev_pulse[SCC_EV_FRAME] & cfg.ext_framing;

  // one master interrupt from the masked flags
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      master_int_reg <= 1'b0;
    end else begin
      master_int_reg <= |(flags & cfg.int_mask);
    end
  end
  assign master_int = master_int_reg;

  // read path, flags sampled live at the read strobe
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_reg <= SCC_READ_NONE;
    end else if (rd_low) begin
      rdata_reg <= {low_reg, flags};
    end else if (rd_high) begin
      rdata_reg <= {1'b0, high_reg};
    end else if (port_rd) begin
      rdata_reg <= SCC_READ_NONE;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      rvalid_reg <= 1'b0;
    end else begin
      rvalid_reg <= port_rd;
    end
  end

  assign port_rdata = rdata_reg;
  assign port_rvalid = rvalid_reg;
endmodule
`default_nettype wire

// *** tb/scc_control_regs_properties.sv ***
// concurrent checks on the control register ports
`timescale 1ns/1ns
`default_nettype none
module scc_control_regs_properties (
  input wire logic clk_sys, // clock
  input wire logic sys_rst, // reset
  input wire logic [2:0] port_addr, // port number
  input wire logic port_wr, // write strobe
  input wire logic port_rd, // read strobe
  input wire logic [15:0] port_wdata, // write data
  input wire logic port_rvalid, // read valid
  input wire logic port1_external, // port 1 unmapped
  input wire logic frame_sync_pulse, // frame pulse
  input wire logic general_output_flag, // output pin
  input wire logic sclk_is_input, // clock direction
  input wire logic frame_transfer_start, // transfer start
  input wire logic [3:0] int_flags // flags
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  sequence low_wr;
    port_wr && port_addr == 3'h0;
  endsequence
  rd_answer_a: assert property (port_rd |=> port_rvalid)
    else $error("read not answered");
  rd_quiet_a: assert property (!port_rd |=> !port_rvalid)
    else $error("valid without read");
  frame_set_a: assert property ($rose(frame_sync_pulse) |=> int_flags[3])
    else $error("frame flag not set");
  flag_clear_a: assert property (low_wr ##0 port_wdata[3] && !frame_sync_pulse |=> !int_flags[3])
    else $error("flag not cleared");
  flag_keep_a: assert property (
    int_flags[3] && !(port_wr && port_addr == 3'h0 && port_wdata[3]) |=> int_flags[3])
    else $error("flag lost");
  out_flag_a: assert property (low_wr |=> general_output_flag == $past(port_wdata[10]))
    else $error("output flag wrong");
  clk_dir_a: assert property (low_wr |=> sclk_is_input == $past(port_wdata[15]))
    else $error("clock direction wrong");
  port1_map_a: assert property (low_wr |=> port1_external == !$past(port_wdata[8]))
    else $error("port 1 mapping wrong");
  start_cause_a: assert property (
    frame_transfer_start |-> frame_sync_pulse ##1 !frame_transfer_start)
    else $error("transfer start wrong");
endmodule
bind scc_control_regs scc_control_regs_properties u_props (.clk_sys(clk_sys), .sys_rst(sys_rst),
  .port_addr(port_addr), .port_wr(port_wr), .port_rd(port_rd), .port_wdata(port_wdata),
  .port_rvalid(port_rvalid), .port1_external(port1_external), .frame_sync_pulse(frame_sync_pulse),
  .general_output_flag(general_output_flag), .sclk_is_input(sclk_is_input),
  .frame_transfer_start(frame_transfer_start), .int_flags(int_flags));
`default_nettype wire

// *** tb/scc_control_regs_test.sv ***
// self-checking bench for the control register
`timescale 1ns/1ns
`default_nettype none
module scc_control_regs_test
  import scc_pkg::*;
;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [2:0] port_addr = 3'h0;
  logic port_wr = 1'b0;
  logic port_rd = 1'b0;
  logic [15:0] port_wdata = 16'h0000;
  logic [15:0] port_rdata;
  logic port_rvalid, port1_external, general_output_flag, sclk_is_input;
  logic frame_transfer_start, master_int;
  logic [3:0] ev = 4'h0;
  logic [3:0] int_flags;
  scc_cfg_s cfg;
  int bad_count = 0;
  int n_compared = 0;
  // address, write data, read back
  logic [34:0] rows [7] = '{{3'h0, 16'hB988, 16'hB980}, {3'h1, 16'h7FFF, 16'h7FFF},
    {3'h1, 16'h7CFE, 16'h7CFE}, {3'h0, 16'h3888, 16'h3880}, {3'h1, 16'h1234, 16'h0000},
    {3'h2, 16'hFFFF, 16'h0000}, {3'h0, 16'h0480, 16'h0480}};
  scc_control_regs i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .port_addr(port_addr),
    .port_wr(port_wr), .port_rd(port_rd), .port_wdata(port_wdata), .port_rdata(port_rdata),
    .port_rvalid(port_rvalid), .port1_external(port1_external),
    .external_interrupt_input(ev[0]), .receive_frame_sync(ev[1]),
    .transmit_frame_sync(ev[2]), .frame_sync_pulse(ev[3]), .cfg(cfg),
    .general_output_flag(general_output_flag), .sclk_is_input(sclk_is_input),
    .frame_transfer_start(frame_transfer_start), .int_flags(int_flags), .master_int(master_int));
  always #4 clk_sys = ~clk_sys;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    port_wr <= 1'b1;
    port_addr <= a;
    port_wdata <= d;
    @(posedge clk_sys);
    port_wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [15:0] exp);
    @(posedge clk_sys);
    port_rd <= 1'b1;
    port_addr <= a;
    @(posedge clk_sys);
    port_rd <= 1'b0;
    #1 chk({15'h0, port_rvalid}, 16'h0001);
    chk(port_rdata, exp);
  endtask
  // one-cycle event on input i
  task automatic pulse(input int i, input logic fts);
    @(posedge clk_sys);
    ev[i] <= 1'b1;
    #1 chk({15'h0, frame_transfer_start}, {15'h0, fts});
    @(posedge clk_sys);
    ev[i] <= 1'b0;
    #1 chk({15'h0, int_flags[i]}, 16'h0001);
  endtask
  task automatic end_of_test();
    $display("compared %0d bad %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rd(3'h0, 16'h8000);
    chk({15'h0, port1_external}, 16'h0001);
    for (int k = 0; k < 7; k++) begin
      wr(rows[k][34:32], rows[k][31:16]);
      rd(rows[k][34:32], rows[k][15:0]);
    end
    chk({1'b0, cfg.io_control, cfg.frame_pulse_long, cfg.sclk_prescale, cfg.frame_modulus},
      16'h7CFE);
    chk({14'h0, general_output_flag, sclk_is_input}, 16'h0002);
    pulse(3, 1'b0);
    @(posedge clk_sys);
    #1 chk({15'h0, master_int}, 16'h0001);
    wr(3'h0, 16'h0288);
    #1 chk({12'h0, int_flags}, 16'h0000);
    for (int i = 0; i < 4; i++) pulse(i, i == 3);
    rd(3'h0, 16'h028F);
    wr(3'h0, 16'h0285);
    rd(3'h0, 16'h028A);
    // companding fields, and masks all off
    wr(3'h0, 16'h6800);
    #1 chk({12'h0, cfg.alaw_sel, cfg.compand_en, cfg.compand_mode}, 16'h000D);
    @(posedge clk_sys);
    #1 chk({15'h0, master_int}, 16'h0000);
    // second reset in mid-run
    @(posedge clk_sys);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    #1 chk(port_rdata, 16'h0000);
    chk({12'h0, int_flags}, 16'h0000);
    chk({14'h0, master_int, sclk_is_input}, 16'h0001);
    rd(3'h0, 16'h8000);
    end_of_test();
  end
  initial begin
    #20000;
    bad_count++;
    end_of_test();
  end
endmodule
`default_nettype wire
